/* File: core/iord_map.svh */
`ifndef IORD_MAP_SVH
`define IORD_MAP_SVH

// address space limits
`define IORD_IO_LAST     8'h3F
`define IORD_BIT_LAST    8'h1F
`define IORD_DS_OFFSET   8'h20
`define IORD_EXT_FIRST   8'h60

// direct i/o locations of the implemented registers, plus one reserved location
`define IORD_A_PB_PIN    6'h03
`define IORD_A_PB_DIR    6'h04
`define IORD_A_PB_OUT    6'h05
`define IORD_A_PC_PIN    6'h06
`define IORD_A_PC_DIR    6'h07
`define IORD_A_PC_OUT    6'h08
`define IORD_A_PD_PIN    6'h09
`define IORD_A_PD_DIR    6'h0A
`define IORD_A_PD_OUT    6'h0B
`define IORD_A_T0_FLG    6'h15
`define IORD_A_T1_FLG    6'h16
`define IORD_A_T2_FLG    6'h17
`define IORD_A_PC_FLG    6'h1B
`define IORD_A_EI_FLG    6'h1C
`define IORD_A_EI_MSK    6'h1D
`define IORD_A_RSVD      6'h10

// implemented bits per register
`define IORD_M_FULL      8'hFF
`define IORD_M_PORT_C    8'h7F
`define IORD_M_T0_FLG    8'h07
`define IORD_M_T1_FLG    8'h27
`define IORD_M_T2_FLG    8'h07
`define IORD_M_PC_FLG    8'h07
`define IORD_M_EI_FLG    8'h03
`define IORD_M_EI_MSK    8'h03

// reset value and flag bank shape
`define IORD_RST_VAL     8'h00
`define IORD_ZERO        8'h00
`define IORD_NFLAG       5
`define IORD_FI_T0       0
`define IORD_FI_T1       1
`define IORD_FI_T2       2
`define IORD_FI_PC       3
`define IORD_FI_EI       4

`endif

/* File: core/iord_pkg.sv */
package iord_pkg;

	// kinds of access the core can make
	typedef enum logic [3:0] {
		IORD_OP_NONE,
		IORD_OP_IO_IN,
		IORD_OP_IO_OUT,
		IORD_OP_SET_BIT_IN_IO,
		IORD_OP_CLEAR_BIT_IN_IO,
		IORD_OP_SKIP_IF_IO_BIT_SET,
		IORD_OP_SKIP_IF_IO_BIT_CLEAR,
		IORD_OP_DATA_SPACE_LOAD,
		IORD_OP_DATA_SPACE_STORE
	} iord_op_t;

	// one access from the core
	typedef struct packed {
		iord_op_t    op;
		logic [7:0]  addr;
		logic [2:0]  bit_sel;
		logic [7:0]  wdata;
	} iord_req_t;

	// answer to the core, one cycle after the request
	typedef struct packed {
		logic        valid;
		logic [7:0]  rdata;
		logic        skip;
	} iord_rsp_t;

	// strobe towards the extended register space
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} iord_ext_t;

endpackage : iord_pkg

/* File: core/iord_flag_bank.sv */
`timescale 1ns/10ps
`default_nettype none

// sticky event flags, cleared by writing one
module iord_flag_bank #(
	parameter int              N    = 5,
	parameter logic [N-1:0][7:0] MASK = '0
) (
	// clock and synchronised reset
	input  wire logic              clock_in,
	input  wire logic              rstn_in,
	// events and clear strobes
	input  wire logic [N-1:0][7:0] set_in,
	input  wire logic [N-1:0][7:0] clr_in,
	// flag state
	output logic      [N-1:0][7:0] flags_out
);

	// one register per flag byte, each with a local flop of its own
	// so that no two processes ever share one variable
	for (genvar i = 0; i < N; i++) begin : g_reg
		logic [7:0] bits_r;  // sticky flags of this register
		// set is or-ed in after the clear, so an event in the
		// clearing cycle wins
		always_ff @(posedge clock_in or negedge rstn_in) begin
			if (!rstn_in)
				bits_r <= '0;
			else
				bits_r <= (set_in[i] | (bits_r & ~clr_in[i])) &
					MASK[i];
		end
		// reserved bits never hold a one
		assign flags_out[i] = bits_r;
	end

endmodule : iord_flag_bank
`default_nettype wire

/* File: core/iord_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "iord_map.svh"

module iord_top
	import iord_pkg::*;
(
	// clock and reset
	input  wire logic       clock_in,
	input  wire logic       rstn_in,
	// core access port
	input  wire iord_req_t  core_req_in,
	output iord_rsp_t       core_rsp_out,
	// extended register space
	output iord_ext_t       ext_req_out,
	input  wire logic [7:0] ext_rdata_in,
	// port pins
	input  wire logic [7:0] port_b_pin_in,
	input  wire logic [7:0] port_c_pin_in,
	input  wire logic [7:0] port_d_pin_in,
	output logic      [7:0] port_b_out,
	output logic      [7:0] port_b_dir_out,
	output logic      [7:0] port_c_out,
	output logic      [7:0] port_c_dir_out,
	output logic      [7:0] port_d_out,
	output logic      [7:0] port_d_dir_out,
	// peripheral events and flags
	input  wire logic [4:0][7:0] flag_evt_in,
	output logic      [4:0][7:0] flag_out,
	output logic      [7:0] ext_irq_mask_out
);

	// implemented bits of each flag register
	localparam logic [4:0][7:0] FLAG_MASK = {
		`IORD_M_EI_FLG, `IORD_M_PC_FLG, `IORD_M_T2_FLG,
		`IORD_M_T1_FLG, `IORD_M_T0_FLG};
	// i/o location of each flag register
	localparam logic [4:0][5:0] FLAG_ADDR = {
		`IORD_A_EI_FLG, `IORD_A_PC_FLG, `IORD_A_T2_FLG,
		`IORD_A_T1_FLG, `IORD_A_T0_FLG};

	logic [1:0]      rst_sync_r;   // reset release chain
	logic            rstn;         // synchronised reset
	logic [2:0][7:0] pin_meta_r;   // first synchroniser stage
	logic [2:0][7:0] pin_sync_r;   // second stage, safe to read
	logic [7:0]      pb_dir_r;     // port b direction
	logic [7:0]      pb_out_r;     // port b output latch
	logic [7:0]      pc_dir_r;     // port c direction
	logic [7:0]      pc_out_r;     // port c output latch
	logic [7:0]      pd_dir_r;     // port d direction
	logic [7:0]      pd_out_r;     // port d output latch
	logic [7:0]      ei_msk_r;     // external irq mask
	iord_rsp_t       rsp_r;        // registered answer
	iord_rsp_t       rsp_nxt;      // next answer

	// reset is asserted at once, released on the clock
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rstn = rst_sync_r[1];

	// pins are asynchronous, so two flops before any use
	always_ff @(posedge clock_in or negedge rstn) begin
		if (!rstn) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= {port_d_pin_in, port_c_pin_in,
				port_b_pin_in};
			pin_sync_r <= pin_meta_r;
		end
	end

	// ---- request decode ----
	iord_op_t   op;         // requested operation
	logic       is_io;      // direct in or out
	logic       is_bit;     // single-bit set or clear
	logic       is_skip;    // single-bit test
	logic       is_ds;      // data-space load or store
	logic [7:0] ds_sub;     // data address less the offset
	logic       io_ok;      // direct access inside window
	logic       bit_ok;     // bit access inside low window
	logic       ds_io;      // load/store landing on i/o
	logic       ds_ext;     // load/store on extended space
	logic       hit;        // access reaches an i/o location
	logic [5:0] io_idx;     // i/o location addressed
	logic [7:0] onehot;     // selected bit as a mask

	assign op      = core_req_in.op;
	assign is_io   = (op == IORD_OP_IO_IN) ||
		(op == IORD_OP_IO_OUT);
	assign is_bit  = (op == IORD_OP_SET_BIT_IN_IO) ||
		(op == IORD_OP_CLEAR_BIT_IN_IO);
	assign is_skip = (op == IORD_OP_SKIP_IF_IO_BIT_SET) ||
		(op == IORD_OP_SKIP_IF_IO_BIT_CLEAR);
	assign is_ds   = (op == IORD_OP_DATA_SPACE_LOAD) ||
		(op == IORD_OP_DATA_SPACE_STORE);
	assign ds_sub  = core_req_in.addr - `IORD_DS_OFFSET;

	// direct window is 0x00..0x3F, data view is shifted
	assign io_ok   = is_io && (core_req_in.addr <= `IORD_IO_LAST);
	assign ds_io   = is_ds &&
		(core_req_in.addr >= `IORD_DS_OFFSET) &&
		(core_req_in.addr < `IORD_EXT_FIRST);
	// bit instructions only reach the lowest 32
	assign bit_ok  = (is_bit || is_skip) &&
		(core_req_in.addr <= `IORD_BIT_LAST);
	// extended space only for load and store
	assign ds_ext  = is_ds && (core_req_in.addr >= `IORD_EXT_FIRST);
	assign hit     = io_ok || bit_ok || ds_io;
	assign io_idx  = is_ds ? ds_sub[5:0] : core_req_in.addr[5:0];
	assign onehot  = 8'h01 << core_req_in.bit_sel;

	// ---- read mux; reserved bits and places give zero ----
	logic [7:0] rd_val;     // current content of the location
	always_comb begin
		rd_val = `IORD_ZERO;
		if (hit) begin
			case (io_idx)
				`IORD_A_PB_PIN: rd_val = pin_sync_r[0];
				`IORD_A_PB_DIR: rd_val = pb_dir_r;
				`IORD_A_PB_OUT: rd_val = pb_out_r;
				`IORD_A_PC_PIN: rd_val = pin_sync_r[1] &
					`IORD_M_PORT_C;
				`IORD_A_PC_DIR: rd_val = pc_dir_r;
				`IORD_A_PC_OUT: rd_val = pc_out_r;
				`IORD_A_PD_PIN: rd_val = pin_sync_r[2];
				`IORD_A_PD_DIR: rd_val = pd_dir_r;
				`IORD_A_PD_OUT: rd_val = pd_out_r;
				`IORD_A_T0_FLG: rd_val = flag_out[`IORD_FI_T0];
				`IORD_A_T1_FLG: rd_val = flag_out[`IORD_FI_T1];
				`IORD_A_T2_FLG: rd_val = flag_out[`IORD_FI_T2];
				`IORD_A_PC_FLG: rd_val = flag_out[`IORD_FI_PC];
				`IORD_A_EI_FLG: rd_val = flag_out[`IORD_FI_EI];
				`IORD_A_EI_MSK: rd_val = ei_msk_r;
				default:        rd_val = `IORD_ZERO;
			endcase
		end
	end

	// ---- write path ----
	logic       wr_full;    // whole-byte write
	logic       set_b;      // single-bit set
	logic       clr_b;      // single-bit clear
	logic       wr_any;     // any write to the location
	logic [7:0] new_val;    // value for plain registers
	logic [7:0] w1c_val;    // clear pattern for flag registers

	assign wr_full = hit && ((op == IORD_OP_IO_OUT) ||
		(op == IORD_OP_DATA_SPACE_STORE));
	assign set_b   = bit_ok && (op == IORD_OP_SET_BIT_IN_IO);
	assign clr_b   = bit_ok && (op == IORD_OP_CLEAR_BIT_IN_IO);
	assign wr_any  = wr_full || set_b || clr_b;
	// read-modify-write touches only the named bit
	assign new_val = wr_full ? core_req_in.wdata :
		set_b ? (rd_val | onehot) : (rd_val & ~onehot);
	// bit set clears just that flag, bit clear writes zero
	assign w1c_val = wr_full ? core_req_in.wdata :
		set_b ? onehot : `IORD_ZERO;

	logic we_pb_dir, we_pb_out, we_pc_dir, we_pc_out;
	logic we_pd_dir, we_pd_out, we_ei_msk;
	assign we_pb_dir = wr_any && (io_idx == `IORD_A_PB_DIR);
	assign we_pb_out = wr_any && (io_idx == `IORD_A_PB_OUT);
	assign we_pc_dir = wr_any && (io_idx == `IORD_A_PC_DIR);
	assign we_pc_out = wr_any && (io_idx == `IORD_A_PC_OUT);
	assign we_pd_dir = wr_any && (io_idx == `IORD_A_PD_DIR);
	assign we_pd_out = wr_any && (io_idx == `IORD_A_PD_OUT);
	assign we_ei_msk = wr_any && (io_idx == `IORD_A_EI_MSK);

	// plain registers; reserved bits are masked off on write
	always_ff @(posedge clock_in or negedge rstn) begin
		if (!rstn) begin
			pb_dir_r <= `IORD_RST_VAL;
			pb_out_r <= `IORD_RST_VAL;
			pc_dir_r <= `IORD_RST_VAL;
			pc_out_r <= `IORD_RST_VAL;
			pd_dir_r <= `IORD_RST_VAL;
			pd_out_r <= `IORD_RST_VAL;
			ei_msk_r <= `IORD_RST_VAL;
		end else begin
			if (we_pb_dir) pb_dir_r <= new_val;
			if (we_pb_out) pb_out_r <= new_val;
			if (we_pc_dir) pc_dir_r <= new_val & `IORD_M_PORT_C;
			if (we_pc_out) pc_out_r <= new_val & `IORD_M_PORT_C;
			if (we_pd_dir) pd_dir_r <= new_val;
			if (we_pd_out) pd_out_r <= new_val;
			if (we_ei_msk) ei_msk_r <= new_val & `IORD_M_EI_MSK;
		end
	end

	// ---- flag registers ----
	logic [4:0][7:0] flag_clr;  // clear strobes per flag register
	for (genvar k = 0; k < `IORD_NFLAG; k++) begin : g_fclr
		assign flag_clr[k] = (wr_any && (io_idx == FLAG_ADDR[k])) ?
			w1c_val : `IORD_ZERO;
	end

	iord_flag_bank #(
		.N    (`IORD_NFLAG),
		.MASK (FLAG_MASK)
	) iord_flag_bank_inst (
		.clock_in  (clock_in),
		.rstn_in   (rstn),
		.set_in    (flag_evt_in),
		.clr_in    (flag_clr),
		.flags_out (flag_out)
	);

	// ---- answer to the core, always one cycle later ----
	logic sel_bit;          // tested bit of the location
	assign sel_bit = rd_val[core_req_in.bit_sel];
	always_comb begin
		rsp_nxt       = '0;
		rsp_nxt.valid = (op != IORD_OP_NONE);
		if (op == IORD_OP_IO_IN || op == IORD_OP_DATA_SPACE_LOAD)
			rsp_nxt.rdata = ds_ext ? ext_rdata_in : rd_val;
		if (bit_ok && op == IORD_OP_SKIP_IF_IO_BIT_SET)
			rsp_nxt.skip = sel_bit;
		if (bit_ok && op == IORD_OP_SKIP_IF_IO_BIT_CLEAR)
			rsp_nxt.skip = ~sel_bit;
	end

	always_ff @(posedge clock_in or negedge rstn) begin
		if (!rstn)
			rsp_r <= '0;
		else
			rsp_r <= rsp_nxt;
	end

	// extended space strobe is combinational so its read data
	// lands in the same answer cycle as an i/o read
	always_comb begin
		ext_req_out       = '0;
		ext_req_out.rd    = ds_ext &&
			(op == IORD_OP_DATA_SPACE_LOAD);
		ext_req_out.wr    = ds_ext &&
			(op == IORD_OP_DATA_SPACE_STORE);
		ext_req_out.addr  = ds_ext ? core_req_in.addr : `IORD_ZERO;
		ext_req_out.wdata = ds_ext ? core_req_in.wdata : `IORD_ZERO;
	end

	// ---- outputs ----
	assign core_rsp_out     = rsp_r;
	assign port_b_out       = pb_out_r;
	assign port_b_dir_out   = pb_dir_r;
	assign port_c_out       = pc_out_r;
	assign port_c_dir_out   = pc_dir_r;
	assign port_d_out       = pd_out_r;
	assign port_d_dir_out   = pd_dir_r;
	assign ext_irq_mask_out = ei_msk_r;

	// ---- checks ----
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rstn);

	a_io_out_map: assert property (
		(op == IORD_OP_IO_OUT && core_req_in.addr ==
		{2'b00, `IORD_A_PB_OUT}) |=> port_b_out == $past(core_req_in.wdata))
		else $error("direct write missed port b output");
	a_ds_offset_map: assert property (
		(op == IORD_OP_DATA_SPACE_STORE && core_req_in.addr ==
		({2'b00, `IORD_A_PB_DIR} + `IORD_DS_OFFSET))
		|=> port_b_dir_out == $past(core_req_in.wdata))
		else $error("data-space store missed port b direction");
	a_set_bit_one: assert property (
		(op == IORD_OP_SET_BIT_IN_IO && core_req_in.addr ==
		{2'b00, `IORD_A_PD_OUT})
		|=> port_d_out == ($past(port_d_out) | $past(onehot)))
		else $error("bit set changed wrong bits");
	a_clr_bit_one: assert property (
		(op == IORD_OP_CLEAR_BIT_IN_IO && core_req_in.addr ==
		{2'b00, `IORD_A_PD_OUT})
		|=> port_d_out == ($past(port_d_out) & ~$past(onehot)))
		else $error("bit clear changed wrong bits");
	a_skip_test_bit: assert property (
		(op == IORD_OP_SKIP_IF_IO_BIT_CLEAR && bit_ok)
		|=> core_rsp_out.valid && core_rsp_out.skip == !$past(sel_bit))
		else $error("skip answer does not match bit");
	a_w1c_clears: assert property (
		(wr_full && io_idx == `IORD_A_T0_FLG &&
		core_req_in.wdata == `IORD_M_T0_FLG &&
		flag_evt_in[`IORD_FI_T0] == `IORD_ZERO)
		|=> flag_out[`IORD_FI_T0] == `IORD_ZERO)
		else $error("writing ones did not clear flags");
	a_event_wins: assert property (
		(flag_clr[`IORD_FI_EI] != `IORD_ZERO)
		##0 (flag_evt_in[`IORD_FI_EI] != `IORD_ZERO)
		|=> ((flag_out[`IORD_FI_EI] & $past(flag_evt_in[`IORD_FI_EI])
		& `IORD_M_EI_FLG) ==
		($past(flag_evt_in[`IORD_FI_EI]) & `IORD_M_EI_FLG)))
		else $error("event lost against clear");
	a_sbi_keeps_flags: assert property (
		(set_b && io_idx == `IORD_A_T1_FLG &&
		flag_evt_in[`IORD_FI_T1] == `IORD_ZERO)
		|=> flag_out[`IORD_FI_T1] ==
		($past(flag_out[`IORD_FI_T1]) & ~$past(onehot)))
		else $error("bit set cleared other flags");
	a_cbi_no_clear: assert property (
		clr_b && io_idx == `IORD_A_PC_FLG
		|=> (flag_out[`IORD_FI_PC] & $past(flag_out[`IORD_FI_PC]))
		== $past(flag_out[`IORD_FI_PC]))
		else $error("bit clear dropped a flag");
	a_ext_load_only: assert property (
		(ext_req_out.rd || ext_req_out.wr) |->
		is_ds && core_req_in.addr >= `IORD_EXT_FIRST)
		else $error("extended space reached by non load/store");
	a_rsvd_reads_zero: assert property (
		(op == IORD_OP_IO_IN && core_req_in.addr ==
		{2'b00, `IORD_A_RSVD}) |=> core_rsp_out.rdata == `IORD_ZERO)
		else $error("reserved location read non-zero");

	c_ext_store: cover property (ext_req_out.wr);
	c_sbi_flag: cover property (set_b && io_idx == `IORD_A_T0_FLG);
	c_skip_taken: cover property (##1 core_rsp_out.skip);
	c_ds_load_io: cover property (ds_io &&
		op == IORD_OP_DATA_SPACE_LOAD);

endmodule : iord_top
`default_nettype wire

/* File: verification/iord_ext_model.sv */
`timescale 1ns/10ps
`default_nettype none

// stand-in for the extended register space behind the load/store path
module iord_ext_model
	import iord_pkg::*;
(
	// clock
	input  wire logic       clock_in,
	// strobe from the block
	input  wire iord_ext_t  ext_in,
	// read data back to the block
	output logic      [7:0] rdata_out
);
	logic [7:0] mem_r [256];  // plain byte store, one per address
	logic [7:0] last_r;       // last value driven while selected

	// data shows only while read is strobed; otherwise the inverse of
	// the last value, so a stale bus can never pass for a real answer
	assign rdata_out = ext_in.rd ? mem_r[ext_in.addr] : ~last_r;

	// writes land on the edge that takes the store
	always @(posedge clock_in) begin
		if (ext_in.wr) begin
			mem_r[ext_in.addr] <= ext_in.wdata;
		end
		if (ext_in.rd) begin
			last_r <= mem_r[ext_in.addr];
		end
	end

	initial begin
		last_r = 8'h00;
		foreach (mem_r[i]) mem_r[i] = 8'h00;
	end
endmodule : iord_ext_model

`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench
	import iord_pkg::*;
;
	// one table row: request plus what the answer should carry
	typedef struct packed {
		iord_op_t   op;
		logic [7:0] addr;
		logic [2:0] bsel;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic       skip;
	} iord_row_t;

	logic            clock_in;       // 25 MHz system clock
	logic            rstn_in;        // active-low reset
	iord_req_t       req;            // core access request
	iord_rsp_t       rsp;            // core access answer
	iord_ext_t       ext;            // extended space strobe
	logic [7:0]      ext_rdata;      // extended space read data
	logic [4:0][7:0] evt;            // flag event pulses
	logic [4:0][7:0] flg;            // sticky flags
	logic [7:0]      pb_o;           // port b latch
	logic [7:0]      pb_d;           // port b direction
	logic [7:0]      pc_o;           // port c latch
	logic [7:0]      pc_d;           // port c direction
	logic [7:0]      pd_o;           // port d latch
	logic [7:0]      pd_d;           // port d direction
	logic [7:0]      eim;            // external irq mask
	int              n_mismatch;     // mismatches seen
	int              checks_done;    // comparisons made
	iord_row_t       rows [30];      // ordinary cases

	iord_top iord_top_inst (
		.clock_in        (clock_in),
		.rstn_in         (rstn_in),
		.core_req_in     (req),
		.core_rsp_out    (rsp),
		.ext_req_out     (ext),
		.ext_rdata_in    (ext_rdata),
		.port_b_pin_in   (8'h5A),
		.port_c_pin_in   (8'hFF),
		.port_d_pin_in   (8'h3C),
		.port_b_out      (pb_o),
		.port_b_dir_out  (pb_d),
		.port_c_out      (pc_o),
		.port_c_dir_out  (pc_d),
		.port_d_out      (pd_o),
		.port_d_dir_out  (pd_d),
		.flag_evt_in     (evt),
		.flag_out        (flg),
		.ext_irq_mask_out(eim)
	);

	iord_ext_model iord_ext_model_inst (
		.clock_in (clock_in),
		.ext_in   (ext),
		.rdata_out(ext_rdata)
	);

	// free-running clock, 40 ns period
	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	// byte-wide comparison
	task automatic check8(input string n, input logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : check8

	// single-bit comparison
	task automatic check1(input string n, input logic e, g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %b seen %b", n, e, g);
		end
	endtask : check1

	// one request, idle afterwards; the answer stands for one cycle
	task automatic access(input iord_op_t o, input logic [7:0] a,
			input logic [2:0] b, input logic [7:0] w);
		@(posedge clock_in);
		req <= '{o, a, b, w};
		@(posedge clock_in);
		req <= '{IORD_OP_NONE, 8'h00, 3'h0, 8'h00};
		#1;
		check1("valid", 1'b1, rsp.valid);
	endtask : access

	// single closing point of the run
	task automatic finish_test();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	// a hang is cut short well beyond the expected hundred-odd cycles
	initial begin
		#(40 * 5000);
		n_mismatch++;
		finish_test();
	end

	initial begin
		// reserved bits of our writes stay zero below
		rows = '{
			'{IORD_OP_IO_OUT,  8'h05, 3'h0, 8'hA5, 8'h00, 1'b0},
			'{IORD_OP_IO_IN,   8'h05, 3'h0, 8'h00, 8'hA5, 1'b0},
			'{IORD_OP_DATA_SPACE_LOAD, 8'h25, 3'h0, 8'h00, 8'hA5, 1'b0},
			'{IORD_OP_DATA_SPACE_STORE, 8'h27, 3'h0, 8'h7F, 8'h00, 1'b0},
			'{IORD_OP_IO_IN,   8'h07, 3'h0, 8'h00, 8'h7F, 1'b0},
			'{IORD_OP_IO_IN,   8'h03, 3'h0, 8'h00, 8'h5A, 1'b0},
			'{IORD_OP_DATA_SPACE_LOAD, 8'h26, 3'h0, 8'h00, 8'h7F, 1'b0},
			'{IORD_OP_DATA_SPACE_LOAD, 8'h29, 3'h0, 8'h00, 8'h3C, 1'b0},
			'{IORD_OP_SET_BIT_IN_IO, 8'h0A, 3'h3, 8'h00, 8'h00, 1'b0},
			'{IORD_OP_IO_IN,   8'h0A, 3'h0, 8'h00, 8'h08, 1'b0},
			'{IORD_OP_CLEAR_BIT_IN_IO, 8'h05, 3'h0, 8'h00, 8'h00, 1'b0},
			'{IORD_OP_DATA_SPACE_LOAD, 8'h25, 3'h0, 8'h00, 8'hA4, 1'b0},
			'{IORD_OP_SKIP_IF_IO_BIT_SET, 8'h05, 3'h2, 8'h00, 8'h00, 1'b1},
			'{IORD_OP_SKIP_IF_IO_BIT_CLEAR, 8'h05, 3'h2, 8'h00, 8'h00, 1'b0},
			'{IORD_OP_SKIP_IF_IO_BIT_CLEAR, 8'h05, 3'h0, 8'h00, 8'h00, 1'b1},
			'{IORD_OP_SKIP_IF_IO_BIT_SET, 8'h05, 3'h0, 8'h00, 8'h00, 1'b0},
			'{IORD_OP_IO_OUT,  8'h03, 3'h0, 8'hFF, 8'h00, 1'b0},
			'{IORD_OP_IO_IN,   8'h10, 3'h0, 8'h00, 8'h00, 1'b0},
			'{IORD_OP_IO_OUT,  8'h1D, 3'h0, 8'h03, 8'h00, 1'b0},
			'{IORD_OP_IO_IN,   8'h1D, 3'h0, 8'h00, 8'h03, 1'b0},
			'{IORD_OP_IO_IN,   8'h03, 3'h0, 8'h00, 8'h5A, 1'b0},
			'{IORD_OP_DATA_SPACE_STORE, 8'h80, 3'h0, 8'h11, 8'h00, 1'b0},
			'{IORD_OP_IO_OUT,  8'h80, 3'h0, 8'h22, 8'h00, 1'b0},
			'{IORD_OP_IO_IN,   8'h80, 3'h0, 8'h00, 8'h00, 1'b0},
			'{IORD_OP_DATA_SPACE_LOAD, 8'h80, 3'h0, 8'h00, 8'h11, 1'b0},
			'{IORD_OP_DATA_SPACE_STORE, 8'h60, 3'h0, 8'h05, 8'h00, 1'b0},
			'{IORD_OP_DATA_SPACE_LOAD, 8'h60, 3'h0, 8'h00, 8'h05, 1'b0},
			'{IORD_OP_DATA_SPACE_STORE, 8'hFF, 3'h0, 8'hC3, 8'h00, 1'b0},
			'{IORD_OP_DATA_SPACE_LOAD, 8'hFF, 3'h0, 8'h00, 8'hC3, 1'b0},
			'{IORD_OP_DATA_SPACE_LOAD, 8'h05, 3'h0, 8'h00, 8'h00, 1'b0}
		};
		n_mismatch = 0;
		checks_done = 0;
		rstn_in = 1'b0;
		req = '{IORD_OP_NONE, 8'h00, 3'h0, 8'h00};
		evt = '0;
		repeat (12) @(posedge clock_in);
		rstn_in <= 1'b1;
		// two sync flops, then one spare edge before the first request
		repeat (3) @(posedge clock_in);

		// table pass: window mapping, bit ops, skips, reserved, extended
		foreach (rows[i]) begin
			access(rows[i].op, rows[i].addr, rows[i].bsel, rows[i].wdata);
			check8("rdata", rows[i].rdata, rsp.rdata);
			check1("skip", rows[i].skip, rsp.skip);
		end
		check8("port_b_out", 8'hA4, pb_o);
		check8("port_c_dir_out", 8'h7F, pc_d);
		check8("port_d_dir_out", 8'h08, pd_d);
		check8("ext_irq_mask_out", 8'h03, eim);
		// port c latch, port b direction and port d latch, by hand
		access(IORD_OP_IO_OUT, 8'h08, 3'h0, 8'h55);
		check8("port_c_out", 8'h55, pc_o);
		access(IORD_OP_DATA_SPACE_STORE, 8'h24, 3'h0, 8'h3C);
		check8("port_b_dir_out", 8'h3C, pb_d);
		access(IORD_OP_SET_BIT_IN_IO, 8'h0B, 3'h7, 8'h00);
		check8("port_d_out", 8'h80, pd_o);
		access(IORD_OP_CLEAR_BIT_IN_IO, 8'h0B, 3'h7, 8'h00);
		check8("port_d_out", 8'h00, pd_o);

		// raise every flag; unimplemented bits must stay clear
		@(posedge clock_in);
		evt <= {5{8'hFF}};
		@(posedge clock_in);
		evt <= '0;
		#1;
		check8("flags", 8'h07, flg[0]);
		check8("flags", 8'h27, flg[1]);
		check8("flags", 8'h03, flg[4]);
		// writing zero keeps, writing one clears only that bit
		access(IORD_OP_IO_OUT, 8'h16, 3'h0, 8'h00);
		check8("flags", 8'h27, flg[1]);
		access(IORD_OP_IO_OUT, 8'h16, 3'h0, 8'h01);
		check8("flags", 8'h26, flg[1]);
		// single-bit ops must not sweep the neighbouring flags
		access(IORD_OP_SET_BIT_IN_IO, 8'h16, 3'h5, 8'h00);
		check8("flags", 8'h06, flg[1]);
		access(IORD_OP_CLEAR_BIT_IN_IO, 8'h15, 3'h0, 8'h00);
		check8("flags", 8'h07, flg[0]);
		access(IORD_OP_IO_OUT, 8'h15, 3'h0, 8'h07);
		check8("flags", 8'h00, flg[0]);
		access(IORD_OP_DATA_SPACE_STORE, 8'h3B, 3'h0, 8'h02);
		check8("flags", 8'h05, flg[3]);
		access(IORD_OP_CLEAR_BIT_IN_IO, 8'h1B, 3'h0, 8'h00);
		check8("flags", 8'h05, flg[3]);
		access(IORD_OP_IO_IN, 8'h1C, 3'h0, 8'h00);
		check8("rdata", 8'h03, rsp.rdata);

		// event and clear in one cycle: the event keeps its flag
		@(posedge clock_in);
		req <= '{IORD_OP_IO_OUT, 8'h1C, 3'h0, 8'h03};
		evt[4] <= 8'h01;
		@(posedge clock_in);
		req <= '{IORD_OP_NONE, 8'h00, 3'h0, 8'h00};
		evt <= '0;
		#1;
		check8("flags", 8'h01, flg[4]);

		// second reset in mid-run clears latches and flags at once
		@(posedge clock_in);
		rstn_in <= 1'b0;
		#1;
		check8("port_b_out", 8'h00, pb_o);
		check8("flags", 8'h00, flg[1]);
		repeat (2) @(posedge clock_in);
		rstn_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		access(IORD_OP_IO_IN, 8'h05, 3'h0, 8'h00);
		check8("rdata", 8'h00, rsp.rdata);
		finish_test();
	end
endmodule : testbench

`default_nettype wire
